// ---- common/acsd_pkg.sv ----
// Package of shared constants and types for the array channel status and DMA setup link.
package acsd_pkg;
  localparam int unsigned DATA_W   = 16;
  localparam int unsigned SPIN_N   = 5;
  localparam int unsigned FUNC_W   = 3;
  localparam int unsigned SEL_LSB  = 0;
  localparam int unsigned SEL_W    = 2;
  localparam int unsigned SECT_LSB = 0;
  localparam int unsigned SECT_W   = 6;
  localparam int unsigned HEAD_LSB = 6;
  localparam int unsigned HEAD_W   = 5;
  localparam int unsigned BYTE_W   = 8;
  localparam logic [15:0] PTR_RST  = 16'h0000;
  localparam logic [15:0] CNT_RST  = 16'h0000;
  localparam logic [4:0]  SPIN_RST = 5'h01;

  typedef enum logic [2:0] {
    ACSD_F_STATUS = 3'h0,
    ACSD_F_SETADR = 3'h1,
    ACSD_F_SETCNT = 3'h2,
    ACSD_F_RDADR  = 3'h3,
    ACSD_F_RDCNT  = 3'h4,
    ACSD_F_MODE   = 3'h5
  } acsd_func_t;

  typedef enum logic [1:0] {
    ACSD_S_END  = 2'h0,
    ACSD_S_CYL  = 2'h1,
    ACSD_S_SH   = 2'h2,
    ACSD_S_BUS  = 2'h3
  } acsd_sel_t;

  // APB register byte offsets of the processor-side controller.
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_RESULT = 8'h04;
  localparam logic [7:0] REG_STAT   = 8'h08;
  localparam logic [7:0] REG_MEMWR  = 8'h0c;
  localparam logic [7:0] REG_MEMRD  = 8'h10;
  localparam int unsigned CMD_ACC_LSB  = 0;
  localparam int unsigned CMD_FUNC_LSB = 16;
  localparam int unsigned CMD_MOD_BIT  = 20;
endpackage

// ---- common/acsd_if.sv ----
// Interface joining the processor channel end and the adapter end.
`timescale 1ns/100ps
interface acsd_if;
  logic        fn_valid;
  logic        fn_ready;
  logic [2:0]  fn_code;
  logic        fn_mod;
  logic [15:0] fn_acc;
  logic        rsp_valid;
  logic [15:0] rsp_acc;
  logic        par_valid;
  logic        par_ready;
  logic [15:0] par_data;
  logic        par_to_dev;
  logic        mem_valid;
  logic        mem_ready;
  logic [15:0] mem_data;

  modport proc (output fn_valid, fn_code, fn_mod, fn_acc, par_ready, mem_valid, mem_data,
                input fn_ready, rsp_valid, rsp_acc, par_valid, par_data, par_to_dev, mem_ready);
  modport dev  (input fn_valid, fn_code, fn_mod, fn_acc, par_ready, mem_valid, mem_data,
                output fn_ready, rsp_valid, rsp_acc, par_valid, par_data, par_to_dev, mem_ready);
endinterface

// ---- hw/acsd_skid.sv ----
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/100ps
module acsd_skid #(
  parameter int unsigned W = 16
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic [W-1:0] mem_q [2];
  logic         wp_q;
  logic         rp_q;
  logic [1:0]   cnt_q;
  wire          push = in_valid && in_ready;
  wire          pop  = out_valid && out_ready;

  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[rp_q];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q     <= 1'b0;
      rp_q     <= 1'b0;
      cnt_q    <= 2'h0;
      mem_q[0] <= '0;
      mem_q[1] <= '0;
    end else begin
      if (push) begin
        mem_q[wp_q] <= in_data;
        wp_q        <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// ---- hw/acsd_dev.sv ----
// Adapter end: status parcels, spindle selection and parcel streaming.
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/100ps
// Function
// - Status read picks parcel by two accumulator bits.
// - Each parcel ORs all selected spindles.
// - Mode function with modifier one picks spindles.
// - Ending status bytes low then high.
// - Cylinder, sector/head, bus B low A high.
// - Start address loads accumulator bit for bit.
// - Processor loads first parcel memory location.
// - Address increments once per parcel moved.
// - Address readback returns current pointer.
// - Parcel count loads accumulator bit for bit.
// - Processor loads total parcels of transfer.
// - Count decrements once per parcel moved.
// - Count readback returns complemented counter.
module acsd_dev #(
  parameter int unsigned SPIN_N = acsd_pkg::SPIN_N
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  acsd_if.dev                      lnk,
  input  wire logic [SPIN_N*16-1:0] spin_end_status,
  input  wire logic [SPIN_N*16-1:0] spin_cylinder,
  input  wire logic [SPIN_N*6-1:0]  spin_sector,
  input  wire logic [SPIN_N*5-1:0]  spin_head,
  input  wire logic [SPIN_N*8-1:0]  spin_bus_a,
  input  wire logic [SPIN_N*8-1:0]  spin_bus_b,
  input  wire logic                 xfer_to_dev,
  input  wire logic                 rx_valid,
  output logic                      rx_ready,
  input  wire logic [15:0]          rx_data,
  output logic                      tx_valid,
  input  wire logic                 tx_ready,
  output logic [15:0]               tx_data,
  output logic [SPIN_N-1:0]         spin_sel,
  output logic [15:0]               mode_word,
  output logic                      xfer_active
);
  logic [SPIN_N-1:0] spin_q;
  logic [15:0]       mode_q;
  logic [15:0]       adr_q;
  logic [15:0]       cnt_q;
  logic              rsp_v_q;
  logic [15:0]       rsp_q;
  logic              dir_q;

  function automatic logic [15:0] or_sel(input logic [SPIN_N*16-1:0] v,
                                          input logic [SPIN_N-1:0] s);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < SPIN_N; i++) begin
      if (s[i]) begin
        r = r | v[i*16 +: 16];
      end
    end
    return r;
  endfunction

  logic [SPIN_N*16-1:0] sh_flat;
  logic [SPIN_N*16-1:0] bus_flat;
  always_comb begin
    for (int i = 0; i < SPIN_N; i++) begin
      sh_flat[i*16 +: 16]  = {5'h00, spin_head[i*5 +: 5], spin_sector[i*6 +: 6]};
      bus_flat[i*16 +: 16] = {spin_bus_a[i*8 +: 8], spin_bus_b[i*8 +: 8]};
    end
  end

  wire [15:0] par_end = or_sel(spin_end_status, spin_q);
  wire [15:0] par_cyl = or_sel(spin_cylinder, spin_q);
  wire [15:0] par_sh  = or_sel(sh_flat, spin_q);
  wire [15:0] par_bus = or_sel(bus_flat, spin_q);
  wire [1:0]  sel     = lnk.fn_acc[acsd_pkg::SEL_LSB +: acsd_pkg::SEL_W];
  wire [15:0] status_v = (sel == acsd_pkg::ACSD_S_END) ? par_end :
                         (sel == acsd_pkg::ACSD_S_CYL) ? par_cyl :
                         (sel == acsd_pkg::ACSD_S_SH)  ? par_sh  : par_bus;

  wire fn_take = lnk.fn_valid && !rsp_v_q;
  wire is_stat = fn_take && (lnk.fn_code == acsd_pkg::ACSD_F_STATUS);
  wire is_sadr = fn_take && (lnk.fn_code == acsd_pkg::ACSD_F_SETADR);
  wire is_scnt = fn_take && (lnk.fn_code == acsd_pkg::ACSD_F_SETCNT);
  wire is_radr = fn_take && (lnk.fn_code == acsd_pkg::ACSD_F_RDADR);
  wire is_rcnt = fn_take && (lnk.fn_code == acsd_pkg::ACSD_F_RDCNT);
  wire is_mode = fn_take && (lnk.fn_code == acsd_pkg::ACSD_F_MODE);

  // Parcel path: both directions share the buffer, and a parcel counts as moved when the
  // buffer takes it, so pointer and counter step with the data and never run ahead of it.
  wire        active  = (cnt_q != 16'h0000);
  wire        src_v   = dir_q ? lnk.mem_valid : rx_valid;
  wire [15:0] src_d   = dir_q ? lnk.mem_data : rx_data;
  wire        b_in_v  = active && src_v;
  wire        b_in_r;
  wire        b_out_v;
  wire        b_out_r;
  wire [15:0] b_out_d;
  wire        tx_free = !tx_valid || tx_ready;
  acsd_skid #(.W(16)) u_buf (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (b_in_v),
    .in_ready  (b_in_r),
    .in_data   (src_d),
    .out_valid (b_out_v),
    .out_ready (b_out_r),
    .out_data  (b_out_d)
  );
  wire moved  = b_in_v && b_in_r;
  wire tx_ld  = b_out_v && dir_q && tx_free;
  wire setup  = is_sadr || is_scnt;

  assign b_out_r        = dir_q ? tx_free : lnk.par_ready;
  assign lnk.fn_ready   = !rsp_v_q;
  assign lnk.rsp_valid  = rsp_v_q;
  assign lnk.rsp_acc    = rsp_q;
  assign lnk.par_valid  = b_out_v && !dir_q;
  assign lnk.par_data   = b_out_d;
  assign lnk.par_to_dev = dir_q;
  assign lnk.mem_ready  = active && dir_q && b_in_r;
  assign rx_ready       = active && !dir_q && b_in_r;

  // Only one function is in flight: a new one is refused while its answer stands.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_v_q <= 1'b0;
      rsp_q   <= 16'h0000;
    end else begin
      rsp_v_q <= fn_take;
      if (is_stat) begin
        rsp_q <= status_v;
      end else if (is_radr) begin
        rsp_q <= adr_q;
      end else if (is_rcnt) begin
        rsp_q <= ~cnt_q;
      end else if (fn_take) begin
        rsp_q <= lnk.fn_acc;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spin_q <= acsd_pkg::SPIN_RST[SPIN_N-1:0];
      mode_q <= 16'h0000;
    end else begin
      if (is_mode && lnk.fn_mod) begin
        spin_q <= lnk.fn_acc[SPIN_N-1:0];
      end
      if (is_mode && !lnk.fn_mod) begin
        mode_q <= lnk.fn_acc;
      end
    end
  end

  // A set function in the same cycle as a move wins, and that move is not counted.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adr_q <= acsd_pkg::PTR_RST;
      cnt_q <= acsd_pkg::CNT_RST;
      dir_q <= 1'b0;
    end else begin
      if (is_sadr) begin
        adr_q <= lnk.fn_acc;
      end else if (moved && !setup) begin
        adr_q <= adr_q + 16'h0001;
      end
      if (is_scnt) begin
        cnt_q <= lnk.fn_acc;
        dir_q <= xfer_to_dev;
      end else if (moved && !setup) begin
        cnt_q <= cnt_q - 16'h0001;
      end
    end
  end

  // The output register holds a parcel until the spindle side takes it.
  // A stall backs up into the buffer, so no parcel is lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_valid <= 1'b0;
      tx_data  <= 16'h0000;
    end else begin
      if (tx_ld) begin
        tx_valid <= 1'b1;
        tx_data  <= b_out_d;
      end else if (tx_ready) begin
        tx_valid <= 1'b0;
      end
    end
  end

  // Registered copies, so spin_sel, mode_word and xfer_active each come straight from a flip-flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spin_sel    <= '0;
      mode_word   <= 16'h0000;
      xfer_active <= 1'b0;
    end else begin
      spin_sel    <= spin_q;
      mode_word   <= mode_q;
      xfer_active <= active;
    end
  end
endmodule

// ---- hw/acsd_proc.sv ----
// Processor channel end: APB command registers and local memory.
`timescale 1ns/100ps
module acsd_proc #(
  parameter int unsigned MEM_AW = 8
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  acsd_if.proc             lnk
);
  logic [15:0] mem [2**MEM_AW];
  logic        busy_q;
  logic [15:0] result_q;
  logic [MEM_AW-1:0] mptr_q;
  logic [MEM_AW-1:0] wptr_q;
  logic        fv_q;
  logic [2:0]  fc_q;
  logic        fm_q;
  logic [15:0] fa_q;
  logic [MEM_AW-1:0] rptr_q;

  wire acc  = psel && penable;
  wire wr   = acc && pwrite;
  wire a_cmd = (paddr == acsd_pkg::REG_CMD);
  wire a_res = (paddr == acsd_pkg::REG_RESULT);
  wire a_st  = (paddr == acsd_pkg::REG_STAT);
  wire a_mw  = (paddr == acsd_pkg::REG_MEMWR);
  wire a_mr  = (paddr == acsd_pkg::REG_MEMRD);
  wire hit   = a_cmd || a_res || a_st || a_mw || a_mr;
  wire [15:0] cmd_acc = pwdata[acsd_pkg::CMD_ACC_LSB +: 16];
  wire [2:0]  cmd_fn  = pwdata[acsd_pkg::CMD_FUNC_LSB +: 3];
  wire        cmd_mod = pwdata[acsd_pkg::CMD_MOD_BIT];
  // Set-start-address is given the memory index of the first parcel.
  wire is_sadr = wr && a_cmd && !busy_q && (cmd_fn == acsd_pkg::ACSD_F_SETADR);
  wire m_step  = (lnk.par_valid && !lnk.par_to_dev) || (lnk.mem_valid && lnk.mem_ready);
  wire [31:0] rd_v = a_cmd ? {16'h0000, fa_q} :
                     a_res ? {16'h0000, result_q} :
                     a_st  ? {31'h0, busy_q} :
                     a_mr  ? {16'h0000, mem[rptr_q]} : 32'h0;

  assign lnk.fn_valid  = fv_q;
  assign lnk.fn_code   = fc_q;
  assign lnk.fn_mod    = fm_q;
  assign lnk.fn_acc    = fa_q;
  assign lnk.par_ready = 1'b1;
  // Memory offers the parcel at the pointer while the adapter is set to send to the device.
  assign lnk.mem_valid = lnk.par_to_dev;
  assign lnk.mem_data  = mem[mptr_q];

  always_ff @(posedge pclk) begin
    if (wr && a_mw) mem[wptr_q] <= pwdata[15:0];
    else if (lnk.par_valid && !lnk.par_to_dev) mem[mptr_q] <= lnk.par_data;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
      result_q <= 16'h0000;
      mptr_q <= '0;
      wptr_q <= '0;
      rptr_q <= '0;
      fv_q <= 1'b0;
      fc_q <= 3'h0;
      fm_q <= 1'b0;
      fa_q <= 16'h0000;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !(hit);
      prdata  <= rd_v;
      if (wr && a_cmd && !busy_q) begin
        fv_q <= 1'b1;
        fc_q <= cmd_fn;
        fm_q <= cmd_mod;
        fa_q <= cmd_acc;
        busy_q <= 1'b1;
      end else if (fv_q && lnk.fn_ready) begin
        fv_q <= 1'b0;
      end
      if (lnk.rsp_valid) begin
        result_q <= lnk.rsp_acc;
        busy_q <= 1'b0;
      end
      if (is_sadr) mptr_q <= cmd_acc[MEM_AW-1:0];
      else if (m_step) mptr_q <= mptr_q + 1'b1;
      if (wr && a_mw) wptr_q <= wptr_q + 1'b1;
      if (wr && a_mr) rptr_q <= pwdata[MEM_AW-1:0];
      else if (acc && !pwrite && a_mr) rptr_q <= rptr_q + 1'b1;
    end
  end
endmodule

// ---- dv/acsd_checker.sv ----
// Assertions on the function link and the parcel stream between the two ends.
`timescale 1ns/100ps
module acsd_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        fn_valid,
  input wire logic        fn_ready,
  input wire logic [2:0]  fn_code,
  input wire logic        fn_mod,
  input wire logic [15:0] fn_acc,
  input wire logic        rsp_valid,
  input wire logic [15:0] rsp_acc,
  input wire logic        par_valid,
  input wire logic        par_ready,
  input wire logic [15:0] par_data,
  input wire logic        par_to_dev,
  input wire logic        mem_valid,
  input wire logic        mem_ready,
  input wire logic [15:0] mem_data
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [15:0] adr_q, cnt_q;
  logic        adr_ok_q, cnt_ok_q;
  wire         take_w = fn_valid && fn_ready;
  wire         move_w = (par_valid && par_ready) || (mem_valid && mem_ready);
  wire         set_adr = take_w && fn_code == acsd_pkg::ACSD_F_SETADR;
  wire         set_cnt = take_w && fn_code == acsd_pkg::ACSD_F_SETCNT;
  sequence take_s(logic [2:0] c);
    take_w && fn_code == c;
  endsequence
  // The shadow copies are trusted only until a parcel moves.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adr_q <= 16'h0000;
      cnt_q <= 16'h0000;
      adr_ok_q <= 1'b0;
      cnt_ok_q <= 1'b0;
    end else begin
      adr_q <= set_adr ? fn_acc : adr_q;
      cnt_q <= set_cnt ? fn_acc : cnt_q;
      adr_ok_q <= !move_w && (set_adr || adr_ok_q);
      cnt_ok_q <= !move_w && (set_cnt || cnt_ok_q);
    end
  end
  rsp_next_a: assert property (take_w |=> rsp_valid)
    else $error("function not answered next cycle");
  rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid)
    else $error("answer longer than one cycle");
  busy_block_a: assert property (rsp_valid |-> !fn_ready)
    else $error("request accepted while answering");
  req_hold_a: assert property (fn_valid && !fn_ready |=> fn_valid && $stable(fn_acc)
    && $stable(fn_code) && $stable(fn_mod)) else $error("request changed while waiting");
  adr_back_a: assert property (take_s(acsd_pkg::ACSD_F_RDADR) ##0 adr_ok_q
    |=> rsp_acc == adr_q) else $error("address readback differs");
  cnt_back_a: assert property (take_s(acsd_pkg::ACSD_F_RDCNT) ##0 cnt_ok_q
    |=> rsp_acc == ~cnt_q) else $error("count readback not inverted count");
  head_unused_a: assert property (take_s(acsd_pkg::ACSD_F_STATUS) ##0 fn_acc[1:0] == 2'h2
    |=> rsp_acc[15:11] == 5'h00) else $error("unused head bits set");
  zero_cnt_a: assert property (cnt_ok_q && cnt_q == 16'h0000 |-> !move_w)
    else $error("parcel moved with zero count");
  dir_excl_a: assert property (par_valid |-> !par_to_dev && !mem_ready)
    else $error("parcel offered in both directions");
endmodule

// ---- dv/tb_array_channel_status_and_dma_setup.sv ----
// Testbench joining both ends and driving APB and the spindle side.
`timescale 1ns/100ps
module tb_array_channel_status_and_dma_setup;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        rx_valid, rx_ready, to_dev, tx_rdy, tx_valid, xfer_active;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [79:0] sp_end, sp_cyl;
  logic [39:0] sp_a, sp_b;
  logic [29:0] sp_sec;
  logic [24:0] sp_head;
  logic [15:0] rx_data, res, tx_data, mode_word;
  logic [4:0]  spin_sel;
  int          n_errors, compares;
  acsd_if lnk ();
  acsd_proc i_acsd_proc (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lnk(lnk.proc));
  acsd_dev i_acsd_dev (.pclk(pclk), .presetn(presetn), .lnk(lnk.dev), .spin_end_status(sp_end),
    .spin_cylinder(sp_cyl), .spin_sector(sp_sec), .spin_head(sp_head), .spin_bus_a(sp_a),
    .spin_bus_b(sp_b), .xfer_to_dev(to_dev), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_rdy), .tx_data(tx_data),
    .spin_sel(spin_sel), .mode_word(mode_word), .xfer_active(xfer_active));
  acsd_checker i_acsd_checker (.pclk(pclk), .presetn(presetn), .fn_valid(lnk.fn_valid),
    .fn_ready(lnk.fn_ready), .fn_code(lnk.fn_code), .fn_mod(lnk.fn_mod), .fn_acc(lnk.fn_acc),
    .rsp_valid(lnk.rsp_valid), .rsp_acc(lnk.rsp_acc), .par_valid(lnk.par_valid),
    .par_ready(lnk.par_ready), .par_data(lnk.par_data), .par_to_dev(lnk.par_to_dev),
    .mem_valid(lnk.mem_valid), .mem_ready(lnk.mem_ready), .mem_data(lnk.mem_data));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic summarize();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic guard(input int n);
    if (n >= 50) begin
      n_errors++;
      summarize();
    end
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    guard(n);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic fn(input logic [2:0] f, input logic m, input logic [15:0] a);
    int n;
    apb(1'b1, acsd_pkg::REG_CMD, {11'h000, m, 1'b0, f, a});
    n = 0;
    do begin
      apb(1'b0, acsd_pkg::REG_STAT, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 50);
    guard(n);
    apb(1'b0, acsd_pkg::REG_RESULT, 32'h0);
    res = rd[15:0];
  endtask
  task automatic push(input logic [15:0] d);
    int n;
    rx_valid <= 1'b1;
    rx_data <= d;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (rx_ready !== 1'b1 && n < 50);
    guard(n);
  endtask
  task automatic pull(input logic [15:0] x);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (tx_valid !== 1'b1 && n < 50);
    guard(n);
    chk({16'h0, tx_data}, {16'h0, x});
  endtask
  function automatic logic [15:0] exp_st(input logic [1:0] s, input logic [4:0] m);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 5; i++) begin
      if (m[i]) begin
        r = r | (s == 2'h0 ? sp_end[i*16 +: 16] : s == 2'h1 ? sp_cyl[i*16 +: 16] :
          s == 2'h2 ? {5'h00, sp_head[i*5 +: 5], sp_sec[i*6 +: 6]} : {sp_a[i*8 +: 8], sp_b[i*8 +: 8]});
      end
    end
    return r;
  endfunction
  initial begin
    n_errors = 0;
    compares = 0;
    {presetn, psel, penable, pwrite, paddr, pwdata, rx_valid, rx_data, to_dev} = '0;
    tx_rdy = 1'b1;
    for (int i = 0; i < 5; i++) begin
      sp_end[i*16 +: 16] = 16'h0001 << (i * 3);
      sp_cyl[i*16 +: 16] = 16'h8000 >> (i * 3);
      sp_sec[i*6 +: 6] = 6'h01 << i;
      sp_head[i*5 +: 5] = 5'h10 >> i;
      sp_a[i*8 +: 8] = 8'h01 << i;
      sp_b[i*8 +: 8] = 8'h80 >> i;
    end
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    fn(acsd_pkg::ACSD_F_MODE, 1'b1, 16'h001b);
    chk({27'h0, spin_sel}, 32'h1b);
    for (int s = 0; s < 4; s++) begin
      fn(acsd_pkg::ACSD_F_STATUS, 1'b0, 16'(s));
      chk({16'h0, res}, {16'h0, exp_st(2'(s), 5'h1b)});
    end
    fn(acsd_pkg::ACSD_F_MODE, 1'b0, 16'h5a3c);
    chk({27'h0, spin_sel}, 32'h1b);
    chk({16'h0, mode_word}, 32'h5a3c);
    fn(acsd_pkg::ACSD_F_SETADR, 1'b0, 16'hab12);
    fn(acsd_pkg::ACSD_F_RDADR, 1'b0, 16'h0000);
    chk({16'h0, res}, 32'hab12);
    fn(acsd_pkg::ACSD_F_SETCNT, 1'b0, 16'h0003);
    fn(acsd_pkg::ACSD_F_RDCNT, 1'b0, 16'h0000);
    chk({16'h0, res}, 32'hfffc);
    chk({31'h0, xfer_active}, 32'h1);
    for (int k = 0; k < 3; k++) push(16'hc0d0 + 16'(k));
    rx_valid <= 1'b0;
    fn(acsd_pkg::ACSD_F_SETCNT, 1'b0, 16'h0000);
    rx_valid <= 1'b1;
    repeat (8) @(posedge pclk);
    rx_valid <= 1'b0;
    fn(acsd_pkg::ACSD_F_RDADR, 1'b0, 16'h0000);
    chk({16'h0, res}, 32'hab15);
    fn(acsd_pkg::ACSD_F_RDCNT, 1'b0, 16'h0000);
    chk({16'h0, res}, 32'hffff);
    chk({31'h0, xfer_active}, 32'h0);
    apb(1'b1, acsd_pkg::REG_MEMRD, 32'h12);
    for (int k = 0; k < 3; k++) begin
      apb(1'b0, acsd_pkg::REG_MEMRD, 32'h0);
      chk({16'h0, rd[15:0]}, {16'h0, 16'hc0d0 + 16'(k)});
    end
    for (int k = 0; k < 3; k++) apb(1'b1, acsd_pkg::REG_MEMWR, 32'h7e00 + 32'(k));
    tx_rdy <= 1'b0;
    to_dev <= 1'b1;
    fn(acsd_pkg::ACSD_F_SETADR, 1'b0, 16'h0000);
    fn(acsd_pkg::ACSD_F_SETCNT, 1'b0, 16'h0003);
    tx_rdy <= 1'b1;
    for (int k = 0; k < 3; k++) pull(16'h7e00 + 16'(k));
    fn(acsd_pkg::ACSD_F_RDADR, 1'b0, 16'h0000);
    chk({16'h0, res}, 32'h0003);
    fn(acsd_pkg::ACSD_F_RDCNT, 1'b0, 16'h0000);
    chk({16'h0, res}, 32'hffff);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, err}, 32'h1);
    summarize();
  end
endmodule
